//--- hdl/sfrc_top.sv
`timescale 1ns/1ps
`include "sfrc_params.svh"
module sfrc_top #(
  parameter int LONG_DELAY_CYCLES =
    `SFRC_DELAY_LONG_US * `SFRC_CLK_MHZ,
  parameter int SHORT_DELAY_CYCLES =
    `SFRC_DELAY_SHORT_US * `SFRC_CLK_MHZ,
  parameter int WRITE_CYCLES = 1000
) (
  // System
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  // Serial pins
  input wire logic cs_n_i,
  input wire logic sck_i,
  input wire logic si_i,
  output logic so_o,
  output logic so_oe_o,
  // Analogue battery sense, pin level
  input wire logic battery_low_i,
  output logic [1:0] battery_load_o,
  output logic [2:0] battery_threshold_o,
  // Status
  output logic busy_flag_o,
  output logic deepest_sleep_o,
  output logic quad_mode_o,
  output logic pattern_reset_o,
  output logic buffer_undefined_o,
  output logic rmw_start_o,
  output logic nv_write_active_o,
  output logic [7:0] battery_test_control_status_o
);
  localparam int CNT_W = 18;
  logic cs_n_s, sck_s, si_s;
  logic cs_n_d, sck_d;
  logic cs_rise, cs_fall, sck_rise, sck_edge;
  logic cs_sel_s, battery_low_s;
  logic [5:0] bit_cnt;
  logic [7:0] shift;
  logic [7:0] cmd;
  logic [3:0] pattern;
  logic [2:0] pat_cnt;
  logic reset_pending;
  logic busy_flag;
  logic busy_out_mode;
  logic [7:0] sr6;
  sfrc_pkg::sfrc_bat_type bat_state;
  logic [CNT_W-1:0] bat_cnt;
  logic [CNT_W-1:0] wr_cnt;
  logic nv_active;
  logic deepest_sleep;
  logic quad_mode;
  logic byte_end;

  initial begin
    if (LONG_DELAY_CYCLES >= (1 << CNT_W) || SHORT_DELAY_CYCLES < 1 ||
        WRITE_CYCLES >= (1 << CNT_W) || WRITE_CYCLES < 1) begin
      $error("sfrc_top counts exceed counter width");
    end
  end

  sfrc_sync #(
    .WIDTH(4)
  ) u_sync (
    .clk_sys_i(clk_sys_i),
    .reset_n_i(reset_n_i),
    .async_i({~cs_n_i, sck_i, si_i, battery_low_i}),
    .sync_o({cs_sel_s, sck_s, si_s, battery_low_s})
  );
  // Select crosses active high so reset leaves it at its idle level
  assign cs_n_s = !cs_sel_s;

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cs_n_d <= 1'b1;
      sck_d <= 1'b0;
    end else begin
      cs_n_d <= cs_n_s;
      sck_d <= sck_s;
    end
  end

  assign cs_rise = cs_n_s && !cs_n_d;
  assign cs_fall = !cs_n_s && cs_n_d;
  assign sck_rise = sck_s && !sck_d && !cs_n_s;
  assign sck_edge = sck_s != sck_d;
  assign byte_end = bit_cnt[2:0] == 3'h0;

  // [RQ2] Pattern collector; [RQ4] sample at select rise
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pattern <= 4'h0;
      pat_cnt <= 3'h0;
    end else if (sck_edge) begin
      // [RQ6] Clock activity aborts collection
      pattern <= 4'h0;
      pat_cnt <= 3'h0;
    end else if (cs_rise && bit_cnt == 6'h00) begin
      // [RQ24] Mismatch restarts, keeping a low as a new first step
      if (si_s == pat_cnt[0]) begin
        pattern <= {pattern[2:0], si_s};
        pat_cnt <= (pat_cnt == `SFRC_PATTERN_STEPS) ? 3'h0 :
          pat_cnt + 3'h1;
      end else begin
        pattern <= 4'h0;
        pat_cnt <= si_s ? 3'h0 : 3'h1;
      end
    end else if (pat_cnt == `SFRC_PATTERN_STEPS) begin
      pat_cnt <= 3'h0;
    end
  end

  // [RQ5] Fourth match, value 5h, requests reset; [RQ23] defer behind NV
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      reset_pending <= 1'b0;
    end else if (pat_cnt == `SFRC_PATTERN_STEPS &&
        pattern == `SFRC_RESET_PATTERN) begin
      reset_pending <= 1'b1;
    end else if (reset_pending && !nv_active) begin
      reset_pending <= 1'b0;
    end
  end

  logic do_reset;
  assign do_reset = reset_pending && !nv_active;
  assign pattern_reset_o = do_reset;

  // [RQ3] Device never drives serial input; only shifts it in
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      bit_cnt <= 6'h00;
      shift <= 8'h00;
    end else if (cs_n_s) begin
      bit_cnt <= 6'h00;
    end else if (sck_rise) begin
      shift <= {shift[6:0], si_s};
      if (bit_cnt != 6'h3F) begin
        bit_cnt <= bit_cnt + 6'h01;
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cmd <= 8'h00;
    end else if (cs_fall) begin
      cmd <= 8'h00;
    end else if (sck_rise && bit_cnt == `SFRC_BYTE_CLOCKS - 6'h01) begin
      cmd <= {shift[6:0], si_s};
    end
  end

  logic end_ok;
  logic id_done;
  // [RQ11] Only a byte-aligned select rise completes an operation
  assign end_ok = cs_rise && byte_end && bit_cnt != 6'h00;
  // [RQ13] Clock 40 done; 41/42 leave it unaligned
  assign id_done = bit_cnt >= `SFRC_ID_CLOCKS;

  // [RQ12] Wake only after whole command; [RQ7] sleep state tracked
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      deepest_sleep <= 1'b0;
    end else if (do_reset) begin
      deepest_sleep <= 1'b0;
    end else if (end_ok && cmd == `SFRC_CMD_WAKE) begin
      if (bit_cnt == `SFRC_BYTE_CLOCKS || id_done) begin
        deepest_sleep <= 1'b0;
      end
    end else if (end_ok && cmd == `SFRC_CMD_SLEEP) begin
      deepest_sleep <= 1'b1;
    end
  end

  // [RQ10] Reset returns to single-line mode
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      quad_mode <= 1'b0;
    end else if (do_reset) begin
      quad_mode <= 1'b0;
    end else if (end_ok && cmd == `SFRC_CMD_QUAD) begin
      quad_mode <= 1'b1;
    end
  end

  // [RQ7] Buffer undefined after reset in deepest sleep; [RQ8] else kept unless select is low mid-transfer
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      buffer_undefined_o <= 1'b0;
    end else if (do_reset) begin
      buffer_undefined_o <= deepest_sleep || (!cs_n_s && bit_cnt != 6'h00);
    end else if (end_ok && cmd == `SFRC_CMD_PROGRAM) begin
      buffer_undefined_o <= 1'b0;
    end
  end

  // [RQ9] NV write runs to completion, only its copy may corrupt
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      nv_active <= 1'b0;
      wr_cnt <= '0;
    end else if (end_ok && cmd == `SFRC_CMD_NV_WRITE && !busy_flag) begin
      nv_active <= 1'b1;
      wr_cnt <= CNT_W'(WRITE_CYCLES - 1);
    end else if (nv_active) begin
      if (wr_cnt == '0) begin
        nv_active <= 1'b0;
      end else begin
        wr_cnt <= wr_cnt - 1'b1;
      end
    end
  end
  assign nv_write_active_o = nv_active;

  logic prog_go;
  logic [CNT_W-1:0] prog_cnt;
  assign prog_go = end_ok && !busy_flag && !deepest_sleep &&
    (cmd == `SFRC_CMD_PROGRAM || cmd == `SFRC_CMD_RMW);
  // [RQ22] Read-modify-write launched as one operation
  assign rmw_start_o = end_ok && !busy_flag && !deepest_sleep &&
    cmd == `SFRC_CMD_RMW;

  // [RQ14] Busy set at program end, falls when write completes
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      prog_cnt <= '0;
    end else if (prog_go) begin
      prog_cnt <= CNT_W'(WRITE_CYCLES - 1);
    end else if (prog_cnt != '0) begin
      prog_cnt <= prog_cnt - 1'b1;
    end
  end

  always_comb begin
    busy_flag = nv_active || prog_cnt != '0 ||
      bat_state == sfrc_pkg::SFRC_BAT_LOAD;
  end
  assign busy_flag_o = busy_flag;

  // [RQ15] Busy level on output from 25h until select rises
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      busy_out_mode <= 1'b0;
    end else if (cs_n_s || do_reset) begin
      busy_out_mode <= 1'b0;
    end else if (sck_rise && bit_cnt == `SFRC_BYTE_CLOCKS - 6'h01 &&
        {shift[6:0], si_s} == `SFRC_CMD_BUSY_OUT) begin
      busy_out_mode <= 1'b1;
    end
  end

  // [RQ21] Battery test keeps busy set, so 25h shows its end
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      so_o <= 1'b0;
      so_oe_o <= 1'b0;
    end else begin
      so_o <= busy_flag;
      so_oe_o <= busy_out_mode && !cs_n_s;
    end
  end

  // [RQ16] Battery test state machine; [RQ20] delay select
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      bat_state <= sfrc_pkg::SFRC_BAT_IDLE;
      bat_cnt <= '0;
    end else if (do_reset) begin
      bat_state <= sfrc_pkg::SFRC_BAT_IDLE;
    end else begin
      unique case (bat_state)
        sfrc_pkg::SFRC_BAT_IDLE: begin
          if (end_ok && cmd == `SFRC_CMD_BATTERY && !busy_flag) begin
            bat_state <= sfrc_pkg::SFRC_BAT_LOAD;
            bat_cnt <= sr6[`SFRC_DELAY_BIT] ? CNT_W'(LONG_DELAY_CYCLES - 1)
                              : CNT_W'(SHORT_DELAY_CYCLES - 1);
          end
        end
        sfrc_pkg::SFRC_BAT_LOAD: begin
          if (bat_cnt == '0) begin
            bat_state <= sfrc_pkg::SFRC_BAT_IDLE;
          end else begin
            bat_cnt <= bat_cnt - 1'b1;
          end
        end
      endcase
    end
  end

  logic bat_done;
  logic sr6_write;
  assign bat_done = bat_state == sfrc_pkg::SFRC_BAT_LOAD && bat_cnt == '0;
  // Indirect write of the battery register: command, address 06h, data
  assign sr6_write = end_ok && cmd == `SFRC_CMD_WR_SR6 &&
    bit_cnt == `SFRC_SR6_WR_CLOCKS && !busy_flag;
  logic [7:0] addr;
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      addr <= 8'h00;
    end else if (sck_rise && bit_cnt == `SFRC_ADDR_LAST) begin
      addr <= {shift[6:0], si_s};
    end
  end

  // [RQ7] [RQ8] Volatile register defaults on reset
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sr6 <= `SFRC_SR6_RESET;
    end else if (do_reset) begin
      sr6 <= `SFRC_SR6_RESET;
    end else if (bat_done) begin
      // [RQ17] Result by comparison against threshold
      sr6[`SFRC_RESULT_MSB:`SFRC_RESULT_LSB] <= battery_low_s ?
        `SFRC_RESULT_LOW : `SFRC_RESULT_HIGH;
    end else if (end_ok && cmd == `SFRC_CMD_BATTERY && !busy_flag) begin
      sr6[`SFRC_RESULT_MSB:`SFRC_RESULT_LSB] <= `SFRC_RESULT_RUN;
    end else if (sr6_write && addr == `SFRC_SR6_ADDR) begin
      // Result field is read only; software sets the rest
      sr6[`SFRC_SW_MSB:0] <= shift[`SFRC_SW_MSB:0];
    end
  end

  // [RQ18] Threshold code; [RQ19] load code drive the analogue side
  assign battery_threshold_o = sr6[`SFRC_THRESH_MSB:`SFRC_THRESH_LSB];
  assign battery_load_o = sr6[`SFRC_LOAD_MSB:`SFRC_LOAD_LSB];
  assign battery_test_control_status_o = sr6;
  assign deepest_sleep_o = deepest_sleep;
  assign quad_mode_o = quad_mode;

  // Checks
  sequence s_pattern_done;
    pat_cnt == `SFRC_PATTERN_STEPS && pattern == `SFRC_RESET_PATTERN;
  endsequence

  chk_reset_defer: assert property (@(posedge clk_sys_i) // [RQ23]
    disable iff (!reset_n_i) nv_active |-> !pattern_reset_o)
    else $error("reset fired during nv write");
  chk_pattern_fires: assert property (@(posedge clk_sys_i) // [RQ5]
    disable iff (!reset_n_i) s_pattern_done ##1 !nv_active |->
      pattern_reset_o)
    else $error("pattern did not reset");
  chk_reset_mode: assert property (@(posedge clk_sys_i) // [RQ10]
    disable iff (!reset_n_i) pattern_reset_o |=> !quad_mode_o)
    else $error("quad mode survived reset");
  chk_bat_run: assert property (@(posedge clk_sys_i) // [RQ16]
    disable iff (!reset_n_i) $rose(bat_state == sfrc_pkg::SFRC_BAT_LOAD)
      |-> sr6[`SFRC_RESULT_MSB:`SFRC_RESULT_LSB] == `SFRC_RESULT_RUN)
    else $error("battery result not running");
  chk_bat_result: assert property (@(posedge clk_sys_i) // [RQ17]
    disable iff (!reset_n_i) bat_done && !do_reset |=>
      sr6[`SFRC_RESULT_MSB:`SFRC_RESULT_LSB] == ($past(battery_low_s) ?
        `SFRC_RESULT_LOW : `SFRC_RESULT_HIGH))
    else $error("battery result wrong");
  chk_busy_out: assert property (@(posedge clk_sys_i) // [RQ15]
    disable iff (!reset_n_i) so_oe_o |-> so_o == $past(busy_flag))
    else $error("so does not follow busy");
  chk_sck_abort: assert property (@(posedge clk_sys_i) // [RQ6]
    disable iff (!reset_n_i) sck_edge |=> pat_cnt == 3'h0)
    else $error("clock edge did not abort pattern");
  chk_prog_busy: assert property (@(posedge clk_sys_i) // [RQ14]
    disable iff (!reset_n_i) prog_go |=> busy_flag_o [*2])
    else $error("busy not set after program");
endmodule

//--- include/sfrc_params.svh
`ifndef SFRC_PARAMS_SVH
`define SFRC_PARAMS_SVH
// Summary of operation
// [RQ1] Host keeps serial clock static through the whole reset pattern.
// [RQ2] Reset requested when 0101 sampled on four consecutive select rises.
// [RQ3] Host drives serial input at select fall; device never drives it.
// [RQ4] Serial input is sampled as chip select returns high.
// [RQ5] Fourth matching pulse, value 5h, triggers the internal reset.
// [RQ6] Any serial clock edge during collection aborts the pattern.
// [RQ7] Reset in deepest sleep: buffer undefined, all volatile status defaulted.
// [RQ8] Reset elsewhere keeps buffer unless updating; volatile status defaulted.
// [RQ9] Non-volatile copies survive reset; one being written may corrupt.
// [RQ10] After reset the device returns to single-line serial mode.
// [RQ11] Select must rise on byte boundary; mid-byte operations are discarded.
// [RQ12] ABh executes after exactly 8 clocks, ignored after 9 or 10.
// [RQ13] ID read takes 40 clocks; 41 or 42 returns ID, stays asleep.
// [RQ14] Program command ending sets busy flag bit 0 until write finishes.
// [RQ15] Command 25h drives busy flag level onto serial output.
// [RQ16] Battery test EFh sets result field 7:6 to 01 while running.
// [RQ17] Completion gives 10 above threshold, 11 below.
// [RQ18] Threshold field 5:3 selects 1.8V to 3.2V in 200 mV steps.
// [RQ19] Load field 2:1 selects test load from zero to ten milliamps.
// [RQ20] Delay bit 0 selects 100 us or 1 ms load time.
// [RQ21] Command 25h also signals battery test completion.
// [RQ22] Command 0Ah rewrites sequential bytes within one page in one operation.
// [RQ23] Reset during non-volatile register write is deferred until it completes.
// [RQ24] Pattern detector restarts when a sampled level breaks the sequence.
`define SFRC_CMD_PROGRAM 8'h02
`define SFRC_CMD_RMW 8'h0A
`define SFRC_CMD_BUSY_OUT 8'h25
`define SFRC_CMD_WAKE 8'hAB
`define SFRC_CMD_BATTERY 8'hEF
`define SFRC_CMD_RD_SR6 8'h65
`define SFRC_CMD_WR_SR6 8'h71
`define SFRC_CMD_SLEEP 8'h79
`define SFRC_CMD_QUAD 8'h38
`define SFRC_CMD_NV_WRITE 8'h01
`define SFRC_RESET_PATTERN 4'h5
`define SFRC_ID_CLOCKS 6'h28
`define SFRC_BYTE_CLOCKS 6'h08
`define SFRC_RESULT_LSB 6
`define SFRC_RESULT_MSB 7
`define SFRC_SW_MSB 5
`define SFRC_THRESH_MSB 5
`define SFRC_THRESH_LSB 3
`define SFRC_LOAD_MSB 2
`define SFRC_LOAD_LSB 1
`define SFRC_DELAY_BIT 0
`define SFRC_SR6_ADDR 8'h06
`define SFRC_SR6_WR_CLOCKS 6'h18
`define SFRC_ADDR_LAST 6'h0F
`define SFRC_PATTERN_STEPS 3'h4
`define SFRC_RESULT_RUN 2'h1
`define SFRC_RESULT_HIGH 2'h2
`define SFRC_RESULT_LOW 2'h3
`define SFRC_SR6_RESET 8'h00
`define SFRC_DELAY_SHORT_US 100
`define SFRC_DELAY_LONG_US 1000
`define SFRC_CLK_MHZ 250
`endif

//--- include/sfrc_pkg.sv
package sfrc_pkg;
  typedef enum logic [2:0] {
    SFRC_IDLE, SFRC_CMD, SFRC_ADDR, SFRC_DATA, SFRC_IGNORE
  } sfrc_phase_type;
  typedef enum logic [1:0] {
    SFRC_BAT_IDLE, SFRC_BAT_LOAD
  } sfrc_bat_type;
endpackage

//--- hdl/sfrc_sync.sv
`timescale 1ns/1ps
module sfrc_sync #(
  parameter int WIDTH = 3
) (
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] stage;

  initial begin
    if (WIDTH < 1) begin
      $error("sfrc_sync needs WIDTH of at least one");
    end
  end

  // Stage one feeds only stage two to settle metastability
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      stage <= '0;
      sync_o <= '0;
    end else begin
      stage <= async_i;
      sync_o <= stage;
    end
  end
endmodule

//--- testbench/sfrc_host_model.sv
`timescale 1ns/1ps
module sfrc_host_model (
  // Clock
  input wire logic clk_sys_i,
  // Serial pins
  output logic cs_n_o,
  output logic sck_o,
  output logic si_o
);
  initial begin
    cs_n_o = 1'b1;
    sck_o = 1'b0;
    si_o = 1'b0;
  end

  task automatic w(input int n);
    repeat (n) @(negedge clk_sys_i);
  endtask

  task automatic pulse(input logic v, input logic glitch);
    si_o = v;
    cs_n_o = 1'b0;
    w(8);
    // A stray clock edge inside the select is the only fault offered
    if (glitch) begin
      sck_o = 1'b1;
      w(4);
      sck_o = 1'b0;
    end
    w(8);
    cs_n_o = 1'b1;
    w(2);
    si_o = ~v;
    w(8);
  endtask

  task automatic frame(input logic [47:0] bits, input int n,
                       input logic hold);
    cs_n_o = 1'b0;
    for (int i = 0; i < n; i++) begin
      si_o = bits[47 - i];
      w(16);
      sck_o = 1'b1;
      w(15);
      sck_o = 1'b0;
    end
    w(16);
    // Released data line shows the inverse, not a stale level
    si_o = ~si_o;
    if (!hold) cs_n_o = 1'b1;
    w(6);
  endtask

  task automatic release_cs();
    cs_n_o = 1'b1;
    w(6);
  endtask
endmodule

//--- testbench/test_sfrc_top.sv
`timescale 1ns/1ps
module test_sfrc_top;
  // Shortened counts keep the run brief
  localparam int LONG = 600;
  localparam int SHORT = 40;
  localparam int WRITE = 400;
  logic clk_sys_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic battery_low = 1'b0;
  logic cs_n, sck, si, so, so_oe;
  logic [1:0] load;
  logic [2:0] thr;
  logic busy, sleep, quad, prst, bufu, rmw, nvw;
  logic [7:0] sr6;
  int n_mismatch = 0;
  int n_checks = 0;
  int n_rst = 0;
  int n_rmw = 0;

  always #2 clk_sys_i = ~clk_sys_i;

  // Pulses are counted away from the edge that launches them
  always @(negedge clk_sys_i) begin
    if (prst === 1'b1) n_rst++;
    if (rmw === 1'b1) n_rmw++;
  end

  sfrc_host_model host (.clk_sys_i(clk_sys_i), .cs_n_o(cs_n),
    .sck_o(sck), .si_o(si));

  sfrc_top #(.LONG_DELAY_CYCLES(LONG), .SHORT_DELAY_CYCLES(SHORT),
    .WRITE_CYCLES(WRITE)) dut (
    .clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .cs_n_i(cs_n),
    .sck_i(sck), .si_i(si), .so_o(so), .so_oe_o(so_oe),
    .battery_low_i(battery_low), .battery_load_o(load),
    .battery_threshold_o(thr), .busy_flag_o(busy),
    .deepest_sleep_o(sleep), .quad_mode_o(quad),
    .pattern_reset_o(prst), .buffer_undefined_o(bufu),
    .rmw_start_o(rmw), .nv_write_active_o(nvw),
    .battery_test_control_status_o(sr6));

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic stop_test();
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic pat(input logic [3:0] p, input logic g);
    for (int i = 3; i >= 0; i--) host.pulse(p[i], g && i == 1);
  endtask

  task automatic cmd(input logic [7:0] c, input int n);
    host.frame({c, 40'h0}, n, 1'b0);
  endtask

  task automatic wr6(input logic [7:0] d);
    host.frame({8'h71, 8'h06, d, 24'h0}, 24, 1'b0);
  endtask

  task automatic t_pattern();
    int r;
    r = n_rst;
    pat(4'h5, 1'b0);
    chk(8'(n_rst - r), 8'h01);
    r = n_rst;
    pat(4'h5, 1'b1);
    chk(8'(n_rst - r), 8'h00);
  endtask

  task automatic t_restart();
    int r;
    wr6(8'h2D);
    chk(sr6, 8'h2D);
    r = n_rst;
    host.pulse(1'b0, 1'b0);
    pat(4'h5, 1'b0);
    chk(8'(n_rst - r), 8'h01);
    chk(sr6, 8'h00);
  endtask

  task automatic t_modes();
    cmd(8'h38, 8);
    chk(quad, 8'h01);
    pat(4'h5, 1'b0);
    chk(quad, 8'h00);
    cmd(8'h79, 8);
    pat(4'h5, 1'b0);
    chk(bufu, 8'h01);
    cmd(8'hAB, 8);
    pat(4'h5, 1'b0);
    chk(bufu, 8'h00);
  endtask

  task automatic t_wake();
    int lens [5] = '{9, 10, 41, 42, 8};
    cmd(8'h79, 8);
    for (int i = 0; i < 5; i++) begin
      cmd(8'hAB, lens[i]);
      chk(sleep, 8'(i < 4));
    end
    cmd(8'h79, 8);
    cmd(8'hAB, 40);
    chk(sleep, 8'h00);
  endtask

  task automatic t_unaligned();
    int r;
    cmd(8'hEF, 9);
    chk({sr6[7:6], 5'h0, busy}, 8'h00);
    r = n_rmw;
    cmd(8'h0A, 36);
    chk(8'(n_rmw - r), 8'h00);
    cmd(8'h0A, 40);
    chk(8'(n_rmw - r), 8'h01);
  endtask

  task automatic t_battery();
    wr6(8'h2D);
    chk({thr, 3'h0, load}, {3'h5, 3'h0, 2'h2});
    wr6(8'h2C);
    cmd(8'hEF, 8);
    chk({sr6[7:6], 5'h0, busy}, 8'h41);
    host.w(SHORT + 20);
    chk({sr6[7:6], 5'h0, busy}, 8'h80);
    wr6(8'h2D);
    battery_low = 1'b1;
    cmd(8'hEF, 8);
    // Busy level on the output also marks the end of the test
    host.frame({8'h25, 40'h0}, 8, 1'b1);
    chk({sr6[7:6], 3'h0, so_oe, so, busy}, 8'h47);
    host.w(LONG);
    chk({sr6[7:6], 3'h0, so_oe, so, busy}, 8'hC4);
    host.release_cs();
    battery_low = 1'b0;
  endtask

  task automatic t_busy_out();
    host.frame({8'h02, 40'h0}, 40, 1'b0);
    chk(busy, 8'h01);
    host.frame({8'h25, 40'h0}, 8, 1'b1);
    chk({so_oe, so}, 8'h03);
    host.w(WRITE);
    chk({so_oe, so, busy}, 8'h04);
    host.release_cs();
    chk(so_oe, 8'h00);
  endtask

  task automatic t_nv_defer();
    int r;
    host.frame({8'h01, 8'h00, 32'h0}, 16, 1'b0);
    chk(nvw, 8'h01);
    r = n_rst;
    pat(4'h5, 1'b0);
    chk(8'(n_rst - r), 8'h00);
    chk(nvw, 8'h01);
    for (int i = 0; i < 4000 && nvw !== 1'b0; i++) host.w(1);
    host.w(4);
    chk(8'(n_rst - r), 8'h01);
  endtask

  initial begin
    // More than twice the length of a clean run
    #160000;
    n_mismatch++;
    stop_test();
  end

  initial begin
    repeat (20) @(negedge clk_sys_i);
    reset_n_i = 1'b1;
    host.w(4);
    chk(sr6, 8'h00);
    t_pattern();
    t_restart();
    t_modes();
    t_wake();
    t_unaligned();
    t_battery();
    t_busy_out();
    t_nv_defer();
    stop_test();
  end
endmodule
